// ---- hdl/wdr_pkg.sv ----
// package for the countdown watchdog: register map, field layout, timing counts
// assumes one 100 MHz clock and an axi4-lite register bus
package wdr_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [15:0] WDR_CONTROL_INDEX = 16'h0024;
    localparam logic [15:0] WDR_STATUS_INDEX = 16'h0025;
    localparam logic [15:0] WDR_IRQ_MASK_INDEX = 16'h0026;
    localparam logic [11:0] WDR_CONTROL_ADDR = 12'h090;
    localparam logic [11:0] WDR_STATUS_ADDR = 12'h094;
    localparam logic [11:0] WDR_IRQ_MASK_ADDR = 12'h098;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int WDR_ACTIVATE_BIT = 7;
    localparam int WDR_TOP_BIT = 6;
    localparam int WDR_FLAG_BIT = 0;
    localparam logic [7:0] WDR_CONTROL_RESET = 8'h7f;
    localparam logic [6:0] WDR_EXPIRE_FROM = 7'h40;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int WDR_CLK_PERIOD_PS = 10000;
    localparam int WDR_MACHINE_CYCLES = 49152;
    localparam int WDR_PULSE_NS = 500;
    localparam int WDR_PULSE_CYCLES = (WDR_PULSE_NS * 1000) / WDR_CLK_PERIOD_PS;

    localparam logic [1:0] WDR_RESP_OKAY = 2'b00;
    localparam logic [1:0] WDR_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic halt_req;
        logic wait_state;
    } wdr_cpu_t;

    typedef enum logic [1:0] {
        WDR_RUN = 2'b00,
        WDR_PULSE = 2'b01
    } wdr_state_t;

endpackage

// ---- hdl/wdr_pulse.sv ----
// pulse stretcher: holds a low-active reset output for a fixed count of cycles
// assumes a single-cycle trigger on the same clock
`timescale 1ns/100ps
`default_nettype none
module wdr_pulse
    import wdr_pkg::*;
#(
    parameter int CYCLES = WDR_PULSE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fire,
    output logic reset_n,
    output logic busy
);
    initial begin
        if (CYCLES < 1 || CYCLES > 255) begin
            $error("wdr_pulse: CYCLES out of range");
        end
    end

    logic [7:0] count;
    logic [7:0] next_count;

    always_comb begin
        next_count = count;
        if (fire && count == 8'h00) begin
            next_count = 8'(CYCLES);
        end else if (count != 8'h00) begin
            next_count = count - 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end

    assign reset_n = (count == 8'h00);
    assign busy = (count != 8'h00);
endmodule
`default_nettype wire

// ---- hdl/wdr_top.sv ----
// countdown watchdog with axi4-lite register slave and reset pulse output
// assumes the cpu reset feeds aresetn; halt and wait come from cpu logic
`timescale 1ns/100ps
`default_nettype none
module wdr_top
    import wdr_pkg::*;
#(
    parameter int DIVIDE = WDR_MACHINE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_on_resetn,
    input wire wdr_cpu_t cpu,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic reset_out_n,
    output logic halt_enter,
    output logic irq
);
    initial begin
        if (DIVIDE < 2 || DIVIDE > 65536) begin
            $error("wdr_top: DIVIDE out of range");
        end
    end

    // ----------------------------------------------------------------
    // bus write side
    // ----------------------------------------------------------------
    logic aw_held, w_held, b_pend;
    logic [11:0] aw_addr;
    logic [7:0] w_byte;
    logic next_aw_held, next_w_held, next_b_pend;
    logic [11:0] next_aw_addr;
    logic [7:0] next_w_byte;
    logic [1:0] bresp, next_bresp;
    logic wr_fire;
    logic wr_ctrl, wr_stat, wr_mask;

    assign s_axi_awready = !aw_held && !b_pend;
    assign s_axi_wready = !w_held && !b_pend;
    assign s_axi_bvalid = b_pend;
    assign s_axi_bresp = bresp;

    function automatic logic known(input logic [11:0] a);
        return a == WDR_CONTROL_ADDR || a == WDR_STATUS_ADDR || a == WDR_IRQ_MASK_ADDR;
    endfunction

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_byte = w_byte;
        next_b_pend = b_pend;
        next_bresp = bresp;
        wr_fire = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_byte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        end
        if (aw_held && w_held) begin
            wr_fire = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_b_pend = 1'b1;
            next_bresp = known(aw_addr) ? WDR_RESP_OKAY : WDR_RESP_SLVERR;
        end
        if (b_pend && s_axi_bready) begin
            next_b_pend = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_byte <= 8'h00;
            b_pend <= 1'b0;
            bresp <= 2'b00;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_byte <= next_w_byte;
            b_pend <= next_b_pend;
            bresp <= next_bresp;
        end
    end

    // byte lane 0 must be enabled for a store to take effect
    logic lane0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            lane0 <= s_axi_wstrb[0];
        end
    end

    assign wr_ctrl = wr_fire && lane0 && aw_addr == WDR_CONTROL_ADDR;
    assign wr_stat = wr_fire && lane0 && aw_addr == WDR_STATUS_ADDR;
    assign wr_mask = wr_fire && lane0 && aw_addr == WDR_IRQ_MASK_ADDR;

    // ----------------------------------------------------------------
    // watchdog core
    // ----------------------------------------------------------------
    logic active, next_active;
    logic [6:0] count, next_count;
    logic [15:0] div, next_div;
    logic fire;
    logic pulse_busy;
    wdr_state_t state, next_state;

    always_comb begin
        next_active = active;
        next_count = count;
        next_div = div;
        next_state = state;
        fire = 1'b0;
        // wait state is deliberately not consulted here
        if (div == 16'(DIVIDE - 1)) begin
            next_div = 16'h0000;
            next_count = count - 7'h01;
            if (active && count == WDR_EXPIRE_FROM) begin
                fire = 1'b1;
            end
        end else begin
            next_div = div + 16'h0001;
        end
        if (wr_ctrl) begin
            next_count = w_byte[6:0];
            next_div = 16'h0000;
            if (w_byte[WDR_ACTIVATE_BIT]) begin
                next_active = 1'b1;
            end
            // activation already set counts too: a write cannot clear it
            if ((active || w_byte[WDR_ACTIVATE_BIT]) && !w_byte[WDR_TOP_BIT]) begin
                fire = 1'b1;
            end
        end
        if (active && cpu.halt_req) begin
            fire = 1'b1;
        end
        case (state)
            WDR_RUN: begin
                if (fire) begin
                    next_state = WDR_PULSE;
                end
            end
            WDR_PULSE: begin
                fire = 1'b0;
            end
            default: next_state = WDR_RUN;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active <= 1'b0;
            count <= WDR_CONTROL_RESET[6:0];
            div <= 16'h0000;
            state <= WDR_RUN;
        end else begin
            active <= next_active;
            count <= next_count;
            div <= next_div;
            state <= next_state;
        end
    end

    wdr_pulse u_pulse (
        .aclk(aclk),
        .aresetn(aresetn),
        .fire(fire),
        .reset_n(reset_out_n),
        .busy(pulse_busy)
    );

    assign halt_enter = cpu.halt_req && !active;

    // ----------------------------------------------------------------
    // status flag and interrupt
    // ----------------------------------------------------------------
    // the flag survives the ordinary reset; only power-on or a status write with bit 0 set clears it
    logic flag, next_flag, mask, next_mask;
    always_comb begin
        next_flag = flag;
        next_mask = mask;
        if (wr_stat && w_byte[WDR_FLAG_BIT]) begin
            next_flag = 1'b0;
        end
        if (fire) begin
            next_flag = 1'b1;
        end
        if (wr_mask) begin
            next_mask = w_byte[WDR_FLAG_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!power_on_resetn) begin
            flag <= 1'b0;
            mask <= 1'b0;
        end else begin
            flag <= next_flag;
            mask <= next_mask;
        end
    end

    assign irq = flag && mask;

    // ----------------------------------------------------------------
    // bus read side
    // ----------------------------------------------------------------
    logic r_pend, next_r_pend;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    assign s_axi_arready = !r_pend;
    assign s_axi_rvalid = r_pend;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    always_comb begin
        next_r_pend = r_pend;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_arvalid && !r_pend) begin
            next_r_pend = 1'b1;
            next_rresp = WDR_RESP_OKAY;
            case (s_axi_araddr)
                WDR_CONTROL_ADDR: next_rdata = {24'h000000, active, count};
                WDR_STATUS_ADDR: next_rdata = {31'h00000000, flag};
                WDR_IRQ_MASK_ADDR: next_rdata = {31'h00000000, mask};
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = WDR_RESP_SLVERR;
                end
            endcase
        end else if (r_pend && s_axi_rready) begin
            next_r_pend = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_pend <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'b00;
        end else begin
            r_pend <= next_r_pend;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_active_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        active |=> active) else $error("activation bit cleared without reset");
    chk_write_loads: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ctrl |=> count == $past(w_byte[6:0])) else $error("control write not loaded");
    chk_expire_fires: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == WDR_RUN && active && count == WDR_EXPIRE_FROM && div == 16'(DIVIDE - 1))
        |=> !reset_out_n) else $error("expiry gave no reset");
    chk_soft_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == WDR_RUN && wr_ctrl && (active || w_byte[7]) && !w_byte[6]) |=> !reset_out_n)
        else $error("software reset missing");
    chk_halt_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == WDR_RUN && active && cpu.halt_req) |=> !reset_out_n && !$past(halt_enter))
        else $error("halt while active did not reset");
    chk_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        fire |=> flag) else $error("flag not set on watchdog reset");
    chk_no_fire_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (!active && !wr_ctrl) |-> !fire) else $error("reset while disabled");
    chk_pulse_len: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(pulse_busy) |-> !reset_out_n [*8]) else $error("reset pulse too short");
    chk_step: assert property (@(posedge aclk) disable iff (!aresetn)
        (div != 16'(DIVIDE - 1) && !wr_ctrl) |=> count == $past(count))
        else $error("counter moved between steps");
endmodule
`default_nettype wire

// ---- tb/wdr_top_tb.sv ----
// testbench for the countdown watchdog, driving the axi4-lite slave and cpu inputs
// assumes DIVIDE shortened to 8 and aresetn applied by the bench after each reset pulse
`timescale 1ns/100ps
`default_nettype none
module wdr_top_tb;
import wdr_pkg::*;
localparam int DIV = 8;
logic aclk, aresetn, power_on_resetn;
wdr_cpu_t cpu;
logic [11:0] awaddr, araddr;
logic awvalid, awready, wvalid, wready, bvalid, bready;
logic arvalid, arready, rvalid, rready;
logic [31:0] wdata, rdata;
logic [3:0] wstrb;
logic [1:0] bresp, rresp;
logic reset_out_n, halt_enter, irq;
int num_errors = 0;
int num_checks = 0;
wdr_top #(.DIVIDE(DIV)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .power_on_resetn(power_on_resetn), .cpu(cpu), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .reset_out_n(reset_out_n), .halt_enter(halt_enter), .irq(irq));
// ----------------------------------------
// bus and compare tasks
// ----------------------------------------
task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
        num_errors++;
        $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
endtask
// the bus waits have no limit of their own: the watchdog process ends a hang
task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check(bresp, WDR_RESP_OKAY, "write response");
    bready <= 1'b0;
endtask
task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
endtask
task automatic wait_low(input int lim, output int n);
    n = 0;
    while (reset_out_n !== 1'b0 && n < lim) begin
        @(posedge aclk);
        n++;
    end
endtask
// cpu reset follows the pulse, as the system logic would do
task automatic do_reset();
    int n;
    n = 0;
    while (reset_out_n !== 1'b1 && n < 100) begin
        @(posedge aclk);
        n++;
    end
    check(reset_out_n, 1'b1, "reset pulse ended");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_reset_values();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(WDR_CONTROL_ADDR, d, r);
    check(d, 32'h0000007f, "control after reset");
    axi_read(WDR_STATUS_ADDR, d, r);
    check(d, 32'h00000000, "status after reset");
    axi_read(12'h0a0, d, r);
    check(d, 32'h0, "unmapped read data");
    check({30'h0, r}, {30'h0, WDR_RESP_SLVERR}, "unmapped read response");
endtask
task automatic t_expiry();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    axi_write(WDR_CONTROL_ADDR, 32'h000000c2);
    axi_read(WDR_CONTROL_ADDR, d, r);
    check(d, 32'h000000c2, "control loaded");
    wait_low(60, n);
    check(n >= 14 && n <= 26, 1, "expiry time");
    n = 0;
    while (reset_out_n === 1'b0 && n < 100) begin
        @(posedge aclk);
        n++;
    end
    check(n, WDR_PULSE_CYCLES, "pulse width");
    do_reset();
    axi_read(WDR_CONTROL_ADDR, d, r);
    check(d, 32'h0000007f, "control after wdg reset");
    axi_read(WDR_STATUS_ADDR, d, r);
    check(d, 32'h00000001, "flag after wdg reset");
endtask
task automatic t_flag_irq();
    logic [31:0] d;
    logic [1:0] r;
    axi_write(WDR_IRQ_MASK_ADDR, 32'h1);
    @(posedge aclk);
    check(irq, 1'b1, "irq with flag");
    axi_write(WDR_STATUS_ADDR, 32'h1);
    @(posedge aclk);
    check(irq, 1'b0, "irq after clear");
    axi_read(WDR_STATUS_ADDR, d, r);
    check(d, 32'h0, "flag cleared");
endtask
task automatic t_soft_reset();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    axi_write(WDR_CONTROL_ADDR, 32'h000000bf);
    wait_low(5, n);
    check(reset_out_n, 1'b0, "software reset");
    do_reset();
    @(posedge aclk);
    check(irq, 1'b1, "flag after soft reset");
    power_on_resetn <= 1'b0;
    @(posedge aclk);
    power_on_resetn <= 1'b1;
    axi_read(WDR_STATUS_ADDR, d, r);
    check(d, 32'h0, "flag after power on");
endtask
task automatic t_halt();
    int n;
    cpu.halt_req <= 1'b1;
    repeat (2) @(posedge aclk);
    check({halt_enter, reset_out_n}, 2'b11, "halt while inactive");
    cpu.halt_req <= 1'b0;
    axi_write(WDR_CONTROL_ADDR, 32'h000000ff);
    cpu.halt_req <= 1'b1;
    wait_low(5, n);
    check({halt_enter, reset_out_n}, 2'b00, "halt while active");
    cpu.halt_req <= 1'b0;
    do_reset();
endtask
task automatic t_soft_active();
    int n;
    axi_write(WDR_CONTROL_ADDR, 32'h000000ff);
    axi_write(WDR_CONTROL_ADDR, 32'h0000003f);
    wait_low(5, n);
    check(reset_out_n, 1'b0, "reset on clearing top bit while active");
    do_reset();
endtask
task automatic t_no_disable();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    cpu.wait_state <= 1'b1;
    axi_write(WDR_CONTROL_ADDR, 32'h000000ff);
    axi_write(WDR_CONTROL_ADDR, 32'h0000007f);
    axi_read(WDR_CONTROL_ADDR, d, r);
    check(d, 32'h000000ff, "activation kept");
    wait_low(600, n);
    check(n >= 496 && n <= 516, 1, "expiry while waiting");
    cpu.wait_state <= 1'b0;
    do_reset();
endtask
// ----------------------------------------
// clock, reset, sequence
// ----------------------------------------
task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask
initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
end
initial begin
    #200000;
    num_errors++;
    test_done();
end
initial begin
    aresetn = 1'b0; power_on_resetn = 1'b0; cpu = '0;
    awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0;
    bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    power_on_resetn <= 1'b1;
    t_reset_values();
    t_expiry();
    t_flag_irq();
    t_soft_reset();
    t_halt();
    t_soft_active();
    t_no_disable();
    test_done();
end
endmodule
`default_nettype wire
